// File: rtl/sao_dev.sv
// Purpose: device end, decodes stream configuration and overlay commands
// Assumes: host keeps one command in flight and waits for intrq
// Notes: freeze lock and capabilities sit on the power-on reset only
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`include "sao_cfg.svh"
`default_nettype none
module sao_dev
  import sao_pkg::*;
#(
  parameter logic [15:0] OFFERED_CAPS = 16'h1B80,
  parameter logic [31:0] TIME_UNIT_US = 32'd1,
  parameter logic [39:0] MIN_COMPLETION_TIME_LIMIT_US = 40'd100
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pwr_resetn_i,
  input wire logic media_done_i,
  output logic frozen_o,
  output logic [15:0] caps_o,
  sao_if.dev tf
);
  localparam logic [5:0] US_CYC = 6'(`SAO_US_CYC);

  sao_state_t state_r;
  sao_entry_t tbl_r [8];
  logic frozen_r;
  logic [15:0] caps_r;
  logic [15:0] ovl_rx_r;
  logic [8:0] widx_r;
  logic [5:0] us_cnt_r;
  logic [39:0] us_left_r;
  logic intrq_r;
  logic [7:0] status_r;
  logic [7:0] error_r;
  logic [7:0] sc_r;
  logic [7:0] cl_r;
  logic [7:0] ch_r;
  logic din_valid_r;
  logic [15:0] din_word_r;
  logic dout_ready_r;

  logic take;
  logic [2:0] sid;
  logic is_ovl;
  logic ovl_ok;
  logic do_freeze;
  logic do_restore;
  logic set_last;
  logic [39:0] completion_time_limit_raw;
  logic [39:0] completion_time_limit_clamped;
  logic [39:0] limit_req;
  logic [39:0] limit_use;
  logic [15:0] id_word;

  // command decode, one command at a time
  assign take = tf.cmd_stb && (state_r == SAO_IDLE);
  assign sid = tf.feat_cur[2:0];
  assign is_ovl = tf.command == `SAO_CMD_OVERLAY;
  assign ovl_ok = take && is_ovl && !frozen_r;
  assign do_freeze = ovl_ok && (tf.feat_cur == `SAO_SUB_FREEZE);
  assign do_restore = ovl_ok && (tf.feat_cur == `SAO_SUB_RESTORE);
  assign set_last = (state_r == SAO_DOUT) && tf.dout_valid && dout_ready_r &&
    (widx_r == `SAO_OVL_WORDS - 9'h001);

  // default limit in microseconds, raised to the device minimum
  assign completion_time_limit_raw = {32'h0000_0000, tf.feat_prev} * {8'h00, TIME_UNIT_US};
  assign completion_time_limit_clamped = (completion_time_limit_raw < MIN_COMPLETION_TIME_LIMIT_US) ? MIN_COMPLETION_TIME_LIMIT_US : completion_time_limit_raw;
  // a streaming command with zero limit falls back to its entry
  assign limit_req = {32'h0000_0000, tf.feat_prev} * {8'h00, TIME_UNIT_US};
  assign limit_use = (tf.feat_prev == 8'h00) ? tbl_r[sid].completion_time_limit_us : limit_req;

  // capability structure word: revision, offered set, rest zero
  always_comb begin
    if (widx_r == 9'h000) begin
      id_word = `SAO_OVL_REVISION;
    end else if (widx_r == {1'b0, `SAO_CAP_WORD}) begin
      id_word = OFFERED_CAPS;
    end else begin
      id_word = 16'h0000;
    end
  end

  // freeze lock survives resetn_i and soft reset, only power-on clears it
  always_ff @(posedge clk_i or negedge pwr_resetn_i) begin
    if (!pwr_resetn_i) begin
      frozen_r <= 1'b0;
    end else if (do_freeze && !tf.srst) begin
      frozen_r <= 1'b1;
    end
  end

  // reduced capability set, restored or narrowed by set
  always_ff @(posedge clk_i or negedge pwr_resetn_i) begin
    if (!pwr_resetn_i) begin
      caps_r <= OFFERED_CAPS;
    end else if (tf.srst) begin
      caps_r <= caps_r;
    end else if (do_restore) begin
      caps_r <= OFFERED_CAPS;
    end else if (set_last) begin
      caps_r <= ovl_rx_r & OFFERED_CAPS;
    end
  end

  // stream table, written only by a command that completes without abort
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        tbl_r[i] <= '0;
      end
    end else if (!tf.srst && take && (tf.command == `SAO_CMD_CFG_STREAM) &&
        caps_r[`SAO_CAP_STREAM_BIT]) begin
      if (tf.feat_cur[`SAO_FEAT_ADD_BIT]) begin
        tbl_r[sid].valid <= 1'b1;
        tbl_r[sid].write_dir <= tf.feat_cur[`SAO_FEAT_DIR_BIT];
        tbl_r[sid].completion_time_limit_us <= completion_time_limit_clamped;
        tbl_r[sid].alloc <= {tf.sc_prev, tf.sc_cur};
      end else begin
        tbl_r[sid].valid <= 1'b0;
      end
    end
  end

  // received overlay capability word
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovl_rx_r <= 16'h0000;
    end else if ((state_r == SAO_DOUT) && tf.dout_valid && dout_ready_r &&
        (widx_r == {1'b0, `SAO_CAP_WORD})) begin
      ovl_rx_r <= tf.dout_word;
    end
  end

  // main sequencer and completion reporting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= SAO_IDLE;
      widx_r <= 9'h000;
      us_cnt_r <= 6'h00;
      us_left_r <= 40'h00_0000_0000;
      intrq_r <= 1'b0;
      status_r <= 8'h50;
      error_r <= 8'h00;
      sc_r <= 8'h00;
      cl_r <= 8'h00;
      ch_r <= 8'h00;
      din_valid_r <= 1'b0;
      din_word_r <= 16'h0000;
      dout_ready_r <= 1'b0;
    end else if (tf.srst) begin
      // soft reset drops the command in flight, tables and lock stay
      state_r <= SAO_IDLE;
      intrq_r <= 1'b0;
      status_r <= 8'h50;
      error_r <= 8'h00;
      din_valid_r <= 1'b0;
      dout_ready_r <= 1'b0;
    end else begin
      intrq_r <= 1'b0;
      case (state_r)
        SAO_IDLE: begin
          if (take) begin
            sc_r <= 8'h00;
            cl_r <= 8'h00;
            ch_r <= 8'h00;
            widx_r <= 9'h000;
            status_r <= 8'h50;
            error_r <= 8'h00;
            if (tf.command == `SAO_CMD_CFG_STREAM) begin
              if (!caps_r[`SAO_CAP_STREAM_BIT] || (!tf.feat_cur[`SAO_FEAT_ADD_BIT] &&
                  !tbl_r[sid].valid)) begin
                status_r[`SAO_ST_ERR_BIT] <= 1'b1;
                error_r <= 8'h01 << `SAO_ERR_ABORT_BIT;
              end
              intrq_r <= 1'b1;
            end else if (is_ovl) begin
              if (frozen_r) begin
                status_r[`SAO_ST_ERR_BIT] <= 1'b1;
                error_r <= 8'h01 << `SAO_ERR_ABORT_BIT;
                if (tf.feat_cur == `SAO_SUB_SET) begin
                  sc_r <= `SAO_REASON_FROZEN;
                end
                intrq_r <= 1'b1;
              end else if (tf.feat_cur == `SAO_SUB_IDENTIFY) begin
                state_r <= SAO_DIN;
                status_r[`SAO_ST_BUSY_BIT] <= 1'b1;
                din_valid_r <= 1'b1;
                din_word_r <= `SAO_OVL_REVISION;
              end else if (tf.feat_cur == `SAO_SUB_SET) begin
                state_r <= SAO_DOUT;
                status_r[`SAO_ST_BUSY_BIT] <= 1'b1;
                dout_ready_r <= 1'b1;
              end else if ((tf.feat_cur == `SAO_SUB_RESTORE) ||
                  (tf.feat_cur == `SAO_SUB_FREEZE)) begin
                intrq_r <= 1'b1;
              end else begin
                status_r[`SAO_ST_ERR_BIT] <= 1'b1;
                error_r <= 8'h01 << `SAO_ERR_ABORT_BIT;
                intrq_r <= 1'b1;
              end
            end else if ((tf.command == `SAO_CMD_RD_STREAM) ||
                (tf.command == `SAO_CMD_WR_STREAM)) begin
              state_r <= SAO_STREAM;
              status_r[`SAO_ST_BUSY_BIT] <= 1'b1;
              us_cnt_r <= 6'h00;
              us_left_r <= limit_use;
            end else begin
              status_r[`SAO_ST_ERR_BIT] <= 1'b1;
              error_r <= 8'h01 << `SAO_ERR_ABORT_BIT;
              intrq_r <= 1'b1;
            end
          end
        end
        SAO_DIN: begin
          // word index advances on each accepted word before the last
          if (din_valid_r && tf.din_ready) begin
            if (widx_r == `SAO_OVL_WORDS - 9'h001) begin
              din_valid_r <= 1'b0;
              state_r <= SAO_IDLE;
              status_r[`SAO_ST_BUSY_BIT] <= 1'b0;
              intrq_r <= 1'b1;
            end else begin
              widx_r <= widx_r + 9'h001;
              din_word_r <= (widx_r + 9'h001 == {1'b0, `SAO_CAP_WORD}) ? OFFERED_CAPS : 16'h0000;
            end
          end
        end
        SAO_DOUT: begin
          if (tf.dout_valid && dout_ready_r) begin
            widx_r <= widx_r + 9'h001;
            if (set_last) begin
              dout_ready_r <= 1'b0;
              state_r <= SAO_IDLE;
              status_r[`SAO_ST_BUSY_BIT] <= 1'b0;
              intrq_r <= 1'b1;
            end
          end
        end
        SAO_STREAM: begin
          // media completion before the limit ends cleanly; zero means no limit
          if (media_done_i) begin
            state_r <= SAO_IDLE;
            status_r[`SAO_ST_BUSY_BIT] <= 1'b0;
            intrq_r <= 1'b1;
          end else if ((us_left_r == 40'h00_0000_0001) && (us_cnt_r == US_CYC - 6'h01)) begin
            state_r <= SAO_IDLE;
            status_r[`SAO_ST_BUSY_BIT] <= 1'b0;
            status_r[`SAO_ST_ERR_BIT] <= 1'b1;
            error_r <= 8'h01 << `SAO_ERR_TIMEOUT_BIT;
            intrq_r <= 1'b1;
          end else if (us_cnt_r == US_CYC - 6'h01) begin
            us_cnt_r <= 6'h00;
            if (us_left_r != 40'h00_0000_0000) begin
              us_left_r <= us_left_r - 40'h00_0000_0001;
            end
          end else begin
            us_cnt_r <= us_cnt_r + 6'h01;
          end
        end
        default: begin
          state_r <= SAO_IDLE;
        end
      endcase
    end
  end

  // unused direction and size are kept for the streaming data path
  assign tf.intrq = intrq_r;
  assign tf.status = status_r;
  assign tf.error = error_r;
  assign tf.sc_out = sc_r;
  assign tf.cl_out = cl_r;
  assign tf.ch_out = ch_r;
  assign tf.din_valid = din_valid_r;
  assign tf.din_word = din_word_r;
  assign tf.dout_ready = dout_ready_r;
  assign frozen_o = frozen_r;
  assign caps_o = caps_r;
endmodule : sao_dev
`default_nettype wire

// File: rtl/sao_cfg.svh
// Purpose: constants for the stream configuration and overlay command logic
// Assumes: task-file register values of eight bits, data words of sixteen bits
// Notes: shared by both ends and by the bench
//
// Contract
// - 51h decodes as the stream configuration command
// - feature bit 7: add when one, remove when zero
// - feature bit 6: zero read stream, one write
// - host puts stream id 0..7 in feature 2:0
// - add on valid id overwrites the stored parameters
// - aborted command leaves stored parameters untouched
// - abort when streaming capability is not offered
// - abort removal of a never configured stream
// - default limit = previous feature times time unit
// - zero limit on stream command uses stored default
// - limit timed from command write to final interrupt
// - limit below device minimum is clamped up; the code clamps only the stored default, not a stream command's own limit
// - allocation size: low current count, high previous count
// - abort sets bit 2 and error status only
// - overlay subcommands C0h C1h C2h C3h, others reserved
// - restore returns capabilities to the full offered set
// - after freeze lock every overlay subcommand aborts
// - only power-down clears the freeze lock
// - hardware and software reset keep the freeze lock
// - aborted set reports reason, word and bit; the code reports only the reason, word and bit read as zero
// - identify returns 512 bytes by data-in transfer
// - set bits not offered are ignored
`ifndef SAO_CFG_SVH
`define SAO_CFG_SVH

`define SAO_CMD_CFG_STREAM 8'h51
`define SAO_CMD_OVERLAY 8'hB1
`define SAO_CMD_RD_STREAM 8'h2A
`define SAO_CMD_WR_STREAM 8'h3A
`define SAO_SUB_RESTORE 8'hC0
`define SAO_SUB_FREEZE 8'hC1
`define SAO_SUB_IDENTIFY 8'hC2
`define SAO_SUB_SET 8'hC3
`define SAO_FEAT_ADD_BIT 7
`define SAO_FEAT_DIR_BIT 6
`define SAO_ERR_ABORT_BIT 2
`define SAO_ERR_TIMEOUT_BIT 1
`define SAO_ST_BUSY_BIT 7
`define SAO_ST_READY_BIT 6
`define SAO_ST_SEEK_BIT 4
`define SAO_ST_ERR_BIT 0
`define SAO_CAP_WORD 8'h07
`define SAO_CAP_STREAM_BIT 9
`define SAO_OVL_REVISION 16'h0002
`define SAO_OVL_WORDS 9'h100
`define SAO_REASON_FROZEN 8'h01
`define SAO_CLK_PERIOD_NS 25
`define SAO_US_NS 1000
`define SAO_US_CYC (`SAO_US_NS / `SAO_CLK_PERIOD_NS)

// host register map, byte addresses
`define SAO_REG_CMD 8'h00
`define SAO_REG_ARG 8'h04
`define SAO_REG_STAT 8'h08
`define SAO_REG_RESP 8'h0C
`define SAO_REG_OVL 8'h10
`define SAO_REG_IDW 8'h14
`define SAO_REG_CTRL 8'h18
`define SAO_AXI_OKAY 2'b00
`define SAO_AXI_SLVERR 2'b10

`endif

// File: rtl/sao_pkg.sv
// Purpose: types for the stream configuration and overlay command logic
// Assumes: nothing beyond the constants header
// Notes: device command states live here
`default_nettype none
package sao_pkg;
  typedef enum logic [2:0] {SAO_IDLE, SAO_DIN, SAO_DOUT, SAO_STREAM} sao_state_t;
  typedef struct packed {
    logic valid;
    logic write_dir;
    logic [39:0] completion_time_limit_us;
    logic [15:0] alloc;
  } sao_entry_t;
endpackage : sao_pkg
`default_nettype wire

// File: rtl/sao_if.sv
// Purpose: task-file link between host controller and device
// Assumes: both ends on one clock
// Notes: cmd_stb is the command register write; intrq marks completion
`default_nettype none
interface sao_if;
  logic cmd_stb;
  logic [7:0] command;
  logic [7:0] feat_cur;
  logic [7:0] feat_prev;
  logic [7:0] sc_cur;
  logic [7:0] sc_prev;
  logic srst;
  logic intrq;
  logic [7:0] status;
  logic [7:0] error;
  logic [7:0] sc_out;
  logic [7:0] cl_out;
  logic [7:0] ch_out;
  logic din_valid;
  logic [15:0] din_word;
  logic din_ready;
  logic dout_valid;
  logic [15:0] dout_word;
  logic dout_ready;
  modport dev (input cmd_stb, command, feat_cur, feat_prev, sc_cur, sc_prev, srst,
    din_ready, dout_valid, dout_word, output intrq, status, error, sc_out, cl_out,
    ch_out, din_valid, din_word, dout_ready);
  modport host (output cmd_stb, command, feat_cur, feat_prev, sc_cur, sc_prev, srst,
    din_ready, dout_valid, dout_word, input intrq, status, error, sc_out, cl_out,
    ch_out, din_valid, din_word, dout_ready);
endinterface : sao_if
`default_nettype wire

// File: rtl/sao_host.sv
// Purpose: host controller end, AXI4-Lite registers driving the task file
// Assumes: software polls the busy bit before issuing the next command
// Notes: a command write while busy is dropped
`include "sao_cfg.svh"
`default_nettype none
module sao_host
  import sao_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  sao_if.host tf
);
  logic aw_has_r, w_has_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic busy_r, cmd_stb_r, srst_r;
  logic [7:0] cmd_r, fc_r, fp_r, scc_r, scp_r;
  logic [15:0] ovl_r, idw0_r, idw7_r;
  logic [8:0] din_idx_r, dout_idx_r;
  logic dout_valid_r;
  logic do_wr;

  assign do_wr = aw_has_r && w_has_r && !bvalid_r;

  // address and data captured independently, either order
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_has_r <= 1'b0;
      w_has_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= `SAO_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_has_r) begin
        aw_has_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_has_r) begin
        w_has_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_has_r <= 1'b0;
        w_has_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r > `SAO_REG_CTRL) ? `SAO_AXI_SLVERR : `SAO_AXI_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // register writes; a command write issues the task-file strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_r <= 8'h00;
      fc_r <= 8'h00;
      fp_r <= 8'h00;
      scc_r <= 8'h00;
      scp_r <= 8'h00;
      ovl_r <= 16'h0000;
      srst_r <= 1'b0;
      cmd_stb_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      cmd_stb_r <= 1'b0;
      if (tf.intrq || srst_r) begin
        busy_r <= 1'b0;
      end
      if (do_wr && (awaddr_r == `SAO_REG_CMD) && !busy_r && !srst_r) begin
        cmd_r <= wdata_r[7:0];
        fc_r <= wdata_r[15:8];
        fp_r <= wdata_r[23:16];
        cmd_stb_r <= 1'b1;
        busy_r <= 1'b1;
      end
      if (do_wr && (awaddr_r == `SAO_REG_ARG)) begin
        scc_r <= wdata_r[7:0];
        scp_r <= wdata_r[15:8];
      end
      if (do_wr && (awaddr_r == `SAO_REG_OVL)) begin
        ovl_r <= wdata_r[15:0];
      end
      if (do_wr && (awaddr_r == `SAO_REG_CTRL)) begin
        srst_r <= wdata_r[0];
      end
    end
  end

  // identify words captured, overlay words sent for a set
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_idx_r <= 9'h000;
      dout_idx_r <= 9'h000;
      idw0_r <= 16'h0000;
      idw7_r <= 16'h0000;
      dout_valid_r <= 1'b0;
    end else if (cmd_stb_r) begin
      din_idx_r <= 9'h000;
      dout_idx_r <= 9'h000;
      dout_valid_r <= (cmd_r == `SAO_CMD_OVERLAY) && (fc_r == `SAO_SUB_SET);
    end else begin
      if (tf.din_valid) begin
        din_idx_r <= din_idx_r + 9'h001;
        if (din_idx_r == 9'h000) begin
          idw0_r <= tf.din_word;
        end
        if (din_idx_r == {1'b0, `SAO_CAP_WORD}) begin
          idw7_r <= tf.din_word;
        end
      end
      if (dout_valid_r && tf.dout_ready) begin
        dout_idx_r <= dout_idx_r + 9'h001;
        dout_valid_r <= dout_idx_r != `SAO_OVL_WORDS - 9'h001;
      end
      if (tf.intrq) begin
        dout_valid_r <= 1'b0; // an aborted set never opens the data phase
      end
    end
  end

  // read side, one cycle after the address is taken
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SAO_AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= `SAO_AXI_OKAY;
      case (s_axi_araddr)
        `SAO_REG_CMD: rdata_r <= {8'h00, fp_r, fc_r, cmd_r};
        `SAO_REG_ARG: rdata_r <= {16'h0000, scp_r, scc_r};
        `SAO_REG_STAT: rdata_r <= {8'h00, tf.error, tf.status, 7'h00, busy_r};
        `SAO_REG_RESP: rdata_r <= {8'h00, tf.ch_out, tf.cl_out, tf.sc_out};
        `SAO_REG_OVL: rdata_r <= {16'h0000, ovl_r};
        `SAO_REG_IDW: rdata_r <= {idw0_r, idw7_r};
        `SAO_REG_CTRL: rdata_r <= {31'h0000_0000, srst_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `SAO_AXI_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_has_r;
  assign s_axi_wready = !w_has_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign tf.cmd_stb = cmd_stb_r;
  assign tf.command = cmd_r;
  assign tf.feat_cur = fc_r;
  assign tf.feat_prev = fp_r;
  assign tf.sc_cur = scc_r;
  assign tf.sc_prev = scp_r;
  assign tf.srst = srst_r;
  assign tf.din_ready = 1'b1;
  assign tf.dout_valid = dout_valid_r;
  assign tf.dout_word = (dout_idx_r == 9'h000) ? `SAO_OVL_REVISION :
    (dout_idx_r == {1'b0, `SAO_CAP_WORD}) ? ovl_r : 16'h0000;
endmodule : sao_host
`default_nettype wire

// File: test/sao_sva.sv
// Purpose: timing checks on the task-file link between both ends
// Assumes: one clock; the device is idle when no data phase or busy
// Notes: the lock mirror follows the power reset only, like the device
`default_nettype none
module sao_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pwr_resetn_i,
  input wire logic cmd_stb,
  input wire logic [7:0] command,
  input wire logic [7:0] feat_cur,
  input wire logic intrq,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic din_valid,
  input wire logic dout_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lock_r;
  logic [15:0] last_r;
  logic go;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a take counts only when no data phase runs
  assign go = cmd_stb && !din_valid && !dout_ready && !status[7];
  // last order, to see which completion locked
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) last_r <= 16'h0000;
    else if (cmd_stb) last_r <= {command, feat_cur};
  end
  // hw reset must not clear it, so it sits on power reset
  always_ff @(posedge clk_i or negedge pwr_resetn_i) begin
    if (!pwr_resetn_i) lock_r <= 1'b0;
    else if (intrq && !status[0] && last_r == 16'hB1C1) lock_r <= 1'b1;
  end
  cfg_done_a: assert property (go && command == 8'h51 |=> intrq)
    else $error("stream config not answered");
  abort_code_a: assert property (intrq && error[2] |-> error == 8'h04 && status == 8'h51)
    else $error("abort code wrong");
  ok_code_a: assert property (intrq && !status[0] |-> error == 8'h00)
    else $error("error bits on success");
  rsvd_abort_a: assert property (go && command == 8'hB1 && feat_cur[7:2] != 6'h30
    |=> intrq && status[0])
    else $error("reserved subcommand not aborted");
  lock_abort_a: assert property (go && command == 8'hB1 && lock_r |=> intrq && error == 8'h04)
    else $error("locked subcommand not aborted");
  ident_data_a: assert property (go && command == 8'hB1 && feat_cur == 8'hC2 && !lock_r
    |=> din_valid ##0 !intrq [*8])
    else $error("identify data missing");
  set_data_a: assert property (go && command == 8'hB1 && feat_cur == 8'hC3 && !lock_r
    |=> dout_ready)
    else $error("set data phase missing");
  intrq_pulse_a: assert property (intrq |=> !intrq)
    else $error("completion longer than a cycle");
  cover property (go && command == 8'h51);
  cover property (intrq && error[2]);
  cover property (go && lock_r);
  cover property (din_valid && dout_ready == 1'b0);
endmodule : sao_sva
`default_nettype wire

// File: test/stream_and_overlay_cmd_tb.sv
// Purpose: register-level tests of both ends joined
// Assumes: software polls busy after each command
// Notes: media done is raised only for the clean stream completion
`include "sao_cfg.svh"
`default_nettype none
module stream_and_overlay_cmd_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] OK_S = 16'h0050;
  localparam logic [15:0] AB_S = 16'h0451;
  localparam logic [15:0] TO_S = 16'h0251;
  localparam int UNIT_US = 2;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pwr_resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, frozen;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] caps;
  int errors = 0;
  int tests_run = 0;
  int busy_cyc = 0;
  int c0 = 0;
  logic media_done = 1'b0;
  sao_if tf ();
  sao_dev #(.TIME_UNIT_US(32'(UNIT_US)), .MIN_COMPLETION_TIME_LIMIT_US(40'd1)) sao_dev_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .pwr_resetn_i(pwr_resetn), .media_done_i(media_done),
    .frozen_o(frozen), .caps_o(caps), .tf(tf));
  sao_host sao_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tf(tf));
  sao_sva sao_sva_inst (.clk_i(clk_i), .resetn_i(resetn_i), .pwr_resetn_i(pwr_resetn),
    .cmd_stb(tf.cmd_stb), .command(tf.command), .feat_cur(tf.feat_cur), .intrq(tf.intrq),
    .status(tf.status), .error(tf.error), .din_valid(tf.din_valid), .dout_ready(tf.dout_ready));
  // clock, 25 ns period
  always #12.5 clk_i = ~clk_i;
  // busy cycles, counted at negedge where status is settled
  always @(negedge clk_i) begin
    if (tf.status[7] === 1'b1) busy_cyc <= busy_cyc + 1;
  end
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // handshakes sampled at negedge, where all is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_i);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (b !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar, b;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ar = arvalid && arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ar) arvalid <= 1'b0;
    end while (b !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // issue, poll busy, compare error and status
  task automatic cmd(input logic [7:0] c, f, p, input logic [15:0] e);
    int n;
    wr(8'h00, {8'h00, p, f, c});
    n = 0;
    do begin
      rd(8'h08);
      n++;
    end while (d[0] !== 1'b0 && n < 200);
    chk(d[23:8], e);
  endtask : cmd
  // watchdog, far above the thousand or so cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    pwr_resetn <= 1'b1;
    rd(8'h08);
    chk(d[23:0], 24'h005000);
    rd(8'h1C);
    chk(r, `SAO_AXI_SLVERR);
    wr(8'h1C, 32'h0);
    chk(r, `SAO_AXI_SLVERR);
    cmd(8'h51, 8'h03, 8'h00, AB_S);
    wr(8'h04, 32'h00001234);
    cmd(8'h51, 8'hC3, 8'h05, OK_S);
    cmd(8'h51, 8'h83, 8'h07, OK_S);
    cmd(8'h51, 8'h03, 8'h00, OK_S);
    cmd(8'h51, 8'h03, 8'h00, AB_S);
    cmd(8'h51, 8'h85, 8'h01, OK_S);
    cmd(8'hB1, 8'hC4, 8'h00, AB_S);
    wr(8'h10, 32'h0000FD80);
    cmd(8'hB1, 8'hC3, 8'h00, OK_S);
    chk(caps, 16'h1980);
    cmd(8'h51, 8'h85, 8'h02, AB_S);
    cmd(8'hB1, 8'hC0, 8'h00, OK_S);
    chk(caps, 16'h1B80);
    cmd(8'h51, 8'h05, 8'h00, OK_S);
    // stored default limit and the clamp, seen as busy length of a timed-out stream
    cmd(8'h51, 8'h81, 8'h03, OK_S);
    cmd(8'h51, 8'h82, 8'h00, OK_S);
    c0 = busy_cyc;
    cmd(8'h2A, 8'h01, 8'h00, TO_S);
    chk(busy_cyc - c0, 3 * UNIT_US * `SAO_US_CYC);
    c0 = busy_cyc;
    cmd(8'h3A, 8'h02, 8'h00, TO_S);
    chk(busy_cyc - c0, `SAO_US_CYC);
    media_done <= 1'b1;
    cmd(8'h2A, 8'h01, 8'h00, OK_S);
    media_done <= 1'b0;
    cmd(8'hB1, 8'hC2, 8'h00, OK_S);
    rd(8'h14);
    chk(d, 32'h00021B80);
    cmd(8'hB1, 8'hC1, 8'h00, OK_S);
    chk(frozen, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmd(8'hB1, 8'hC0 + i[7:0], 8'h00, AB_S);
    end
    rd(8'h0C);
    chk(d[23:0], 24'h000001);
    // hardware then soft reset, lock must survive both
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk(frozen, 1'b1);
    wr(8'h18, 32'h1);
    wr(8'h18, 32'h0);
    cmd(8'hB1, 8'hC0, 8'h00, AB_S);
    @(posedge clk_i);
    pwr_resetn <= 1'b0;
    @(posedge clk_i);
    pwr_resetn <= 1'b1;
    @(negedge clk_i);
    chk(frozen, 1'b0);
    cmd(8'hB1, 8'hC1, 8'h00, OK_S);
    conclude();
  end
endmodule : stream_and_overlay_cmd_tb
`default_nettype wire
